// [pio_pkg.sv]
// Purpose: Shared constants for the programmed I/O interface bus control logic.
// Assumes: 16-bit device register address and data on a 24-bit multiplexed bus.
// Notes: All offsets, widths, reset values and state codes live here.
package pio_pkg;

	// Width of the multiplexed address/data lines and of the data word.
	localparam int BUS_W = 24;
	localparam int DATA_W = 16;

	// Device register address layout.
	localparam int REG_LSB = 0;
	localparam int REG_W = 3;
	localparam int DEV_LSB = 3;
	localparam int DEV_W = 8;
	localparam int EXT_LSB = 11;
	localparam int EXT_W = 5;

	// Number of devices served and registers per device.
	localparam int NUM_DEV = 4;
	localparam int DEV_IDX_W = 2;
	localparam int NUM_REG = 8;
	localparam int STORE_ADDR_W = DEV_IDX_W + REG_W;
	localparam int STORE_DEPTH = NUM_DEV * NUM_REG;

	// Pin synchroniser depth.
	localparam int SYNC_STAGES = 3;

	// Values after reset. Handshake pins are active low, so idle is high.
	localparam logic PIN_IDLE = 1'h1;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [BUS_W-1:0] BUS_RESET = 24'h000000;
	localparam logic [STORE_ADDR_W-1:0] STORE_ADDR_RESET = 5'h00;

	// Handshake sequencer states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_REQ = 5'h04,
		ST_DRIVE = 5'h08,
		ST_DONE = 5'h10
	} hs_state_type;

endpackage

// [reg_store.sv]
// Purpose: Register storage for all device registers of the interface.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data comes out of a register, one cycle after the address.
module reg_store (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [pio_pkg::STORE_ADDR_W-1:0] wr_addr,
	input wire logic [pio_pkg::DATA_W-1:0] wr_data,
	input wire logic [pio_pkg::STORE_ADDR_W-1:0] rd_addr,
	output logic [pio_pkg::DATA_W-1:0] rd_data_q
);

	logic [pio_pkg::DATA_W-1:0] mem [pio_pkg::STORE_DEPTH];

	// Storage array is not reset; software sees undefined contents until written.
	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read port.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_data_q <= pio_pkg::DATA_RESET;
		end else if (ce) begin
			rd_data_q <= mem[rd_addr];
		end
	end

endmodule

// [pio_bus_interface.sv]
// Purpose: Bus control logic of a multi-device programmed I/O interface module.
// Assumes: Handshake pins arrive asynchronously; straps are static while running.
// Notes: Serves four devices of eight registers each; all handshake pins active low.
// Operation
// [RQ1] CPU requests allocation and names the cycle type to its handshake logic.
// [RQ2] CPU sequencer waits until the handshake logic ends each bus phase.
// [RQ3] After addressing, CPU always sends the accumulator toward the write buffer.
// [RQ4] After the data phase, CPU always loads the data buffer into the accumulator.
// [RQ5] CPU handshake logic starts the cycle only after allocation acknowledge.
// [RQ6] CPU drives the address together with the address present strobe.
// [RQ7] CPU holds the address about 50 ns past the strobe edge.
// [RQ8] CPU drives accumulator data, then asserts transfer enable once valid.
// [RQ9] Output register: latch bus data on transfer enable, then assert transfer done.
// [RQ10] CPU captures bus lines on transfer done edge and restarts its sequencer.
// [RQ11] CPU negates transfer enable; interface then negates transfer done.
// [RQ12] Address phase and data phase start are identical for both directions.
// [RQ13] Input register: interface asserts input request after seeing transfer enable.
// [RQ14] CPU stops driving the bus before asserting input acknowledge.
// [RQ15] On input acknowledge drive the input register, then assert transfer done.
// [RQ16] CPU captures input data on the transfer done edge into its accumulator.
// [RQ17] Latch the bus address on the address present strobe leading edge.
// [RQ18] On transfer enable leading edge compare the latched device number.
// [RQ19] Only a matching interface acts; others stay fully passive.
// [RQ20] Matching interface decodes register bits to select exactly one register.
// [RQ21] One module serves up to four separate devices.
// [RQ22] Compare only with extended address bits 11 to 15 zero and enable active.
// [RQ23] Register select is a 3-to-8 decode, one line per register value.
// [RQ24] All handshake signals are active low.
// [RQ25] Release bus and negate input request once transfer enable is negated.
module pio_bus_interface (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [pio_pkg::BUS_W-1:0] bus_lines_in,
	output logic [pio_pkg::BUS_W-1:0] bus_lines_out_q,
	output logic bus_lines_oe_q,
	input wire logic address_present_strobe_n,
	input wire logic io_transfer_enable_n,
	input wire logic input_acknowledge_n,
	output logic transfer_done_n_q,
	output logic input_request_n_q,
	input wire logic [pio_pkg::NUM_DEV*pio_pkg::DEV_W-1:0] device_numbers,
	input wire logic [pio_pkg::NUM_DEV*pio_pkg::NUM_REG-1:0] input_register_mask,
	input wire logic user_wr_valid,
	input wire logic [pio_pkg::STORE_ADDR_W-1:0] user_wr_addr,
	input wire logic [pio_pkg::DATA_W-1:0] user_wr_data,
	output logic user_wr_taken_q,
	output logic out_wr_valid_q,
	output logic [pio_pkg::STORE_ADDR_W-1:0] out_wr_addr_q,
	output logic [pio_pkg::DATA_W-1:0] out_wr_data_q
);

	// Decodes a register number into one select line per register.
	function automatic logic [pio_pkg::NUM_REG-1:0] reg_select(input logic [pio_pkg::REG_W-1:0] num);
		logic [pio_pkg::NUM_REG-1:0] sel;
		sel = '0;
		sel[num] = 1'h1;
		return sel;
	endfunction

	// Synchroniser chains for the three handshake pins and the bus lines.
	localparam int NUM_CTL = 3;
	logic [NUM_CTL-1:0] ctl_pins;
	logic [NUM_CTL-1:0] ctl_s1_q;
	logic [NUM_CTL-1:0] ctl_s2_q;
	logic [NUM_CTL-1:0] ctl_s3_q;
	logic [NUM_CTL-1:0] ctl_f_q;
	logic [pio_pkg::BUS_W-1:0] bus_s1_q;
	logic [pio_pkg::BUS_W-1:0] bus_s2_q;
	logic [pio_pkg::BUS_W-1:0] bus_s3_q;
	logic [pio_pkg::BUS_W-1:0] bus_f_q;
	logic apr_prev_q;
	logic en_prev_q;

	// Captured straps.
	logic [pio_pkg::NUM_DEV*pio_pkg::DEV_W-1:0] dev_num_q;
	logic [pio_pkg::NUM_DEV*pio_pkg::NUM_REG-1:0] in_mask_q;

	// Latched address and selection.
	logic [pio_pkg::DATA_W-1:0] addr_q;
	logic [pio_pkg::DEV_IDX_W-1:0] dev_idx_q;
	logic [pio_pkg::REG_W-1:0] reg_idx_q;

	pio_pkg::hs_state_type state_q;
	pio_pkg::hs_state_type state_d;

	// Filtered pin levels, active low on the wire.
	assign ctl_pins = {input_acknowledge_n, io_transfer_enable_n, address_present_strobe_n};
	wire apr_on = !ctl_f_q[0]; // RQ24
	wire en_on = !ctl_f_q[1]; // RQ24
	wire ack_on = !ctl_f_q[2]; // RQ24
	wire apr_rise = apr_on && !apr_prev_q;
	wire en_rise = en_on && !en_prev_q;

	// Four flops per pin; a new level counts once stages two and three agree.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CTL; gi++) begin : g_ctl_sync
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					ctl_s1_q[gi] <= pio_pkg::PIN_IDLE;
					ctl_s2_q[gi] <= pio_pkg::PIN_IDLE;
					ctl_s3_q[gi] <= pio_pkg::PIN_IDLE;
					ctl_f_q[gi] <= pio_pkg::PIN_IDLE;
				end else if (ce) begin
					ctl_s1_q[gi] <= ctl_pins[gi];
					ctl_s2_q[gi] <= ctl_s1_q[gi];
					ctl_s3_q[gi] <= ctl_s2_q[gi];
					if (ctl_s2_q[gi] == ctl_s3_q[gi]) begin
						ctl_f_q[gi] <= ctl_s3_q[gi];
					end
				end
			end
		end
	endgenerate

	// Bus lines take the same path, so data and strobes line up in time.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_s1_q <= pio_pkg::BUS_RESET;
			bus_s2_q <= pio_pkg::BUS_RESET;
			bus_s3_q <= pio_pkg::BUS_RESET;
			bus_f_q <= pio_pkg::BUS_RESET;
		end else if (ce) begin
			bus_s1_q <= bus_lines_in;
			bus_s2_q <= bus_s1_q;
			bus_s3_q <= bus_s2_q;
			if (bus_s2_q == bus_s3_q) begin
				bus_f_q <= bus_s3_q;
			end
		end
	end

	// Edge detection on the filtered levels.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			apr_prev_q <= 1'h0;
			en_prev_q <= 1'h0;
		end else if (ce) begin
			apr_prev_q <= apr_on;
			en_prev_q <= en_on;
		end
	end

	// Straps are caught while reset is held, so thumbwheel changes need a reset.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dev_num_q <= device_numbers;
			in_mask_q <= input_register_mask;
		end
	end

	// Address fields of the latched address.
	wire [pio_pkg::EXT_W-1:0] ext_bits = addr_q[pio_pkg::EXT_LSB +: pio_pkg::EXT_W];
	wire [pio_pkg::DEV_W-1:0] dev_field = addr_q[pio_pkg::DEV_LSB +: pio_pkg::DEV_W];
	wire [pio_pkg::REG_W-1:0] reg_field = addr_q[pio_pkg::REG_LSB +: pio_pkg::REG_W];
	wire ext_zero = (ext_bits == '0);

	// One comparator per device served.
	logic [pio_pkg::NUM_DEV-1:0] dev_equal;
	generate
		for (gi = 0; gi < pio_pkg::NUM_DEV; gi++) begin : g_dev_cmp
			assign dev_equal[gi] = ext_zero && (dev_field == dev_num_q[gi*pio_pkg::DEV_W +: pio_pkg::DEV_W]); // RQ21 RQ22
		end
	endgenerate

	// Lowest matching device wins if two thumbwheels were set alike.
	logic [pio_pkg::DEV_IDX_W-1:0] match_idx;
	always_comb begin
		match_idx = '0;
		for (int i = pio_pkg::NUM_DEV - 1; i >= 0; i--) begin
			if (dev_equal[i]) begin
				match_idx = i[pio_pkg::DEV_IDX_W-1:0];
			end
		end
	end
	wire any_match = |dev_equal;

	// Direction comes from the selected register of the matching device.
	wire [pio_pkg::NUM_REG-1:0] reg_sel = reg_select(reg_field); // RQ20 RQ23
	wire [pio_pkg::NUM_REG-1:0] dev_in_mask = in_mask_q[match_idx*pio_pkg::NUM_REG +: pio_pkg::NUM_REG];
	wire sel_is_input = |(reg_sel & dev_in_mask); // RQ13

	// Decision points of the sequencer.
	wire start_xfer = (state_q == pio_pkg::ST_ADDR) && en_rise && any_match; // RQ18 RQ19 RQ22
	wire start_out = start_xfer && !sel_is_input;
	wire start_in = start_xfer && sel_is_input;
	wire bus_write = start_out; // RQ9

	// Sequencer next state.
	always_comb begin
		state_d = state_q;
		case (state_q)
			pio_pkg::ST_IDLE: begin
				if (apr_rise) begin
					state_d = pio_pkg::ST_ADDR;
				end
			end
			pio_pkg::ST_ADDR: begin
				if (apr_rise) begin
					state_d = pio_pkg::ST_ADDR;
				end else if (start_out) begin
					state_d = pio_pkg::ST_DONE; // RQ9
				end else if (start_in) begin
					state_d = pio_pkg::ST_REQ; // RQ13
				end else if (en_rise) begin
					state_d = pio_pkg::ST_IDLE; // RQ19
				end
			end
			pio_pkg::ST_REQ: begin
				if (ack_on) begin
					state_d = pio_pkg::ST_DRIVE; // RQ15
				end else if (!en_on) begin
					state_d = pio_pkg::ST_IDLE; // RQ25
				end
			end
			pio_pkg::ST_DRIVE: begin
				state_d = pio_pkg::ST_DONE; // RQ15
			end
			pio_pkg::ST_DONE: begin
				if (!en_on) begin
					state_d = pio_pkg::ST_IDLE; // RQ11
				end
			end
			default: begin
				state_d = pio_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= pio_pkg::ST_IDLE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// Every module latches the address at the strobe, not yet knowing its target.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_q <= pio_pkg::DATA_RESET;
		end else if (ce && apr_rise && (state_q == pio_pkg::ST_IDLE || state_q == pio_pkg::ST_ADDR)) begin
			addr_q <= bus_f_q[pio_pkg::DATA_W-1:0]; // RQ17 RQ12
		end
	end

	// The selection is frozen for the whole data phase.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dev_idx_q <= '0;
			reg_idx_q <= '0;
		end else if (ce && start_xfer) begin
			dev_idx_q <= match_idx; // RQ19
			reg_idx_q <= reg_field; // RQ20
		end
	end

	// Store write port: a bus write beats a user write, which then waits a cycle.
	wire user_go = user_wr_valid && !bus_write;
	wire store_we = bus_write || user_go;
	wire [pio_pkg::STORE_ADDR_W-1:0] bus_addr = {match_idx, reg_field};
	wire [pio_pkg::STORE_ADDR_W-1:0] store_wa = bus_write ? bus_addr : user_wr_addr;
	wire [pio_pkg::DATA_W-1:0] store_wd = bus_write ? bus_f_q[pio_pkg::DATA_W-1:0] : user_wr_data;
	wire [pio_pkg::DATA_W-1:0] store_rd;

	reg_store u_store (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.wr_en(store_we),
		.wr_addr(store_wa),
		.wr_data(store_wd),
		.rd_addr({dev_idx_q, reg_idx_q}),
		.rd_data_q(store_rd)
	);

	// User-side notice of writes taken and of registers written from the bus.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			user_wr_taken_q <= 1'h0;
			out_wr_valid_q <= 1'h0;
			out_wr_addr_q <= pio_pkg::STORE_ADDR_RESET;
			out_wr_data_q <= pio_pkg::DATA_RESET;
		end else if (ce) begin
			user_wr_taken_q <= user_go;
			out_wr_valid_q <= bus_write; // RQ9
			if (bus_write) begin
				out_wr_addr_q <= bus_addr;
				out_wr_data_q <= bus_f_q[pio_pkg::DATA_W-1:0];
			end
		end
	end

	// Handshake outputs. Transfer done follows the write or one cycle after data is driven.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			transfer_done_n_q <= pio_pkg::PIN_IDLE;
			input_request_n_q <= pio_pkg::PIN_IDLE;
		end else if (ce) begin
			if (start_out) begin
				transfer_done_n_q <= 1'h0; // RQ9 RQ24
			end else if (state_q == pio_pkg::ST_DRIVE) begin
				transfer_done_n_q <= 1'h0; // RQ15
			end else if (state_q == pio_pkg::ST_DONE && !en_on) begin
				transfer_done_n_q <= pio_pkg::PIN_IDLE; // RQ11
			end
			if (start_in) begin
				input_request_n_q <= 1'h0; // RQ13
			end else if (!en_on && (state_q == pio_pkg::ST_REQ || state_q == pio_pkg::ST_DONE)) begin
				input_request_n_q <= pio_pkg::PIN_IDLE; // RQ25
			end
		end
	end

	// Bus drive only after input acknowledge; the register read is already settled.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_lines_out_q <= pio_pkg::BUS_RESET;
			bus_lines_oe_q <= 1'h0;
		end else if (ce) begin
			if (state_q == pio_pkg::ST_REQ && ack_on) begin
				bus_lines_out_q <= {{(pio_pkg::BUS_W - pio_pkg::DATA_W){1'b0}}, store_rd}; // RQ15
				bus_lines_oe_q <= 1'h1; // RQ15
			end else if (!en_on && state_q != pio_pkg::ST_DRIVE) begin
				bus_lines_oe_q <= 1'h0; // RQ25
			end
		end
	end

endmodule

// [pio_bus_monitor.sv]
// Purpose: Concurrent checks on the interface side of the bus handshake.
// Assumes: Pin inputs reach the logic four edges late through synchronisers.
// Notes: Attached to every interface instance by the bind at the foot.
module pio_bus_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [pio_pkg::BUS_W-1:0] bus_lines_in,
	input wire logic bus_lines_oe_q,
	input wire logic io_transfer_enable_n,
	input wire logic input_acknowledge_n,
	input wire logic transfer_done_n_q,
	input wire logic input_request_n_q,
	input wire logic out_wr_valid_q,
	input wire logic [pio_pkg::DATA_W-1:0] out_wr_data_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// An answer needs an enable that has been low long enough to pass the synchroniser.
	sequence enable_settled;
		!io_transfer_enable_n && !$past(io_transfer_enable_n, 3);
	endsequence
	sequence enable_quiet;
		io_transfer_enable_n [*8];
	endsequence
	a_done_needs_enable: assert property ($fell(transfer_done_n_q) |-> enable_settled)
		else $error("Transfer done fell without a settled enable.");
	a_request_needs_enable: assert property ($fell(input_request_n_q) |-> enable_settled)
		else $error("Input request fell without a settled enable.");
	a_release_after_enable: assert property ($rose(io_transfer_enable_n) |->
		##[1:8] (transfer_done_n_q && input_request_n_q && !bus_lines_oe_q))
		else $error("Answer not withdrawn after enable rose.");
	a_idle_when_quiet: assert property (enable_quiet |->
		transfer_done_n_q && input_request_n_q && !bus_lines_oe_q)
		else $error("Interface active while enable is quiet.");
	a_write_matches_bus: assert property (out_wr_valid_q |->
		!io_transfer_enable_n && out_wr_data_q == bus_lines_in[15:0])
		else $error("Output write does not match the bus data.");
	a_drive_needs_ack: assert property (bus_lines_oe_q |-> !input_acknowledge_n)
		else $error("Bus driven without input acknowledge.");
	a_drive_after_request: assert property ($rose(bus_lines_oe_q) |-> !input_request_n_q)
		else $error("Bus driven without an input request.");
	a_data_before_done: assert property ($fell(transfer_done_n_q) && !input_request_n_q |->
		$past(bus_lines_oe_q))
		else $error("Input done before the data was driven.");
endmodule
bind pio_bus_interface pio_bus_monitor pio_bus_monitor_i (.clk(clk), .sys_rst(sys_rst),
	.bus_lines_in(bus_lines_in), .bus_lines_oe_q(bus_lines_oe_q), .io_transfer_enable_n(io_transfer_enable_n),
	.input_acknowledge_n(input_acknowledge_n), .transfer_done_n_q(transfer_done_n_q),
	.input_request_n_q(input_request_n_q), .out_wr_valid_q(out_wr_valid_q), .out_wr_data_q(out_wr_data_q));

// [cpu_handshake_model.sv]
// Purpose: Behavioural model of the processor bus handshake logic.
// Assumes: Allocation is granted at once; only register exchange cycles are run.
// Notes: A missing answer ends the exchange after a bounded wait, with ok low.
module cpu_handshake_model (
	input wire logic clk,
	input wire logic transfer_done_n_q,
	input wire logic input_request_n_q,
	input wire logic [pio_pkg::BUS_W-1:0] bus_lines_in,
	output logic strobe_n,
	output logic enable_n,
	output logic ack_n,
	output logic [pio_pkg::BUS_W-1:0] drive,
	output logic drive_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// Handshake pins idle high and the lines start undriven.
	initial begin
		strobe_n = 1'h1;
		enable_n = 1'h1;
		ack_n = 1'h1;
		drive = 24'h000000;
		drive_oe = 1'h0;
	end
	// The caller stalls inside this task until the data phase has ended.
	task automatic exchange(input logic [15:0] addr, input logic [15:0] acc, output logic [15:0] data_buffer_register,
		output logic ok);
		int n;
		@(posedge clk);
		drive <= {8'h00, addr};
		drive_oe <= 1'h1;
		strobe_n <= 1'h0;
		repeat (7) @(posedge clk);
		drive <= {8'h00, acc};
		repeat (6) @(posedge clk);
		enable_n <= 1'h0;
		n = 0;
		while (transfer_done_n_q !== 1'h0 && n < 40) begin
			@(posedge clk);
			n++;
			if (input_request_n_q === 1'h0 && drive_oe)
				drive_oe <= 1'h0;
			else if (input_request_n_q === 1'h0)
				ack_n <= 1'h0;
		end
		ok = (n < 40);
		data_buffer_register = bus_lines_in[15:0];
		enable_n <= 1'h1;
		n = 0;
		while (transfer_done_n_q !== 1'h1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		strobe_n <= 1'h1;
		ack_n <= 1'h1;
		drive_oe <= 1'h0;
		ok = ok && (n < 40);
		// The strobe must stay idle for a few cycles, or the far side's pin filter misses the gap.
		repeat (4) @(posedge clk);
	endtask
endmodule

// [pio_bus_interface_bench.sv]
// Purpose: Self-checking bench for the programmed interface bus control logic.
// Assumes: Straps stay fixed; the handshake model plays the processor side.
// Notes: Released lines show the inverse of their last value, so stale data cannot pass.
module pio_bus_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] DEV_NUMS = 32'h2c1b0a05;
	localparam logic [31:0] IN_MASK = 32'hff200000;
	logic clk, sys_rst, user_wr_valid, bus_oe, cpu_oe, strobe_n, enable_n, ack_n, done_n, request_n, taken, wr_valid;
	logic [4:0] user_wr_addr, wr_addr;
	logic [15:0] user_wr_data, wr_data;
	logic [23:0] bus_lines_in, bus_out, cpu_drive;
	logic [23:0] last_q = 24'h000000;
	int fails, comparisons;
	int pulses = 0;
	// Whoever owns the lines drives them; otherwise they drift.
	assign bus_lines_in = cpu_oe ? cpu_drive : (bus_oe ? bus_out : ~last_q);
	always @(posedge clk) begin
		last_q <= bus_lines_in;
		if (wr_valid === 1'h1)
			pulses <= pulses + 1;
	end
	pio_bus_interface pio_bus_interface_i (.clk(clk), .sys_rst(sys_rst), .ce(1'h1), .bus_lines_in(bus_lines_in),
		.bus_lines_out_q(bus_out), .bus_lines_oe_q(bus_oe), .address_present_strobe_n(strobe_n),
		.io_transfer_enable_n(enable_n), .input_acknowledge_n(ack_n), .transfer_done_n_q(done_n),
		.input_request_n_q(request_n), .device_numbers(DEV_NUMS), .input_register_mask(IN_MASK),
		.user_wr_valid(user_wr_valid), .user_wr_addr(user_wr_addr), .user_wr_data(user_wr_data),
		.user_wr_taken_q(taken), .out_wr_valid_q(wr_valid), .out_wr_addr_q(wr_addr), .out_wr_data_q(wr_data));
	cpu_handshake_model cpu_handshake_model_i (.clk(clk), .transfer_done_n_q(done_n), .input_request_n_q(request_n),
		.bus_lines_in(bus_lines_in), .strobe_n(strobe_n), .enable_n(enable_n), .ack_n(ack_n),
		.drive(cpu_drive), .drive_oe(cpu_oe));
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic xfer(input logic [7:0] dev, input logic [2:0] r, input logic [4:0] ext, input logic [15:0] acc,
		input logic ok_exp, output logic [15:0] data_buffer_register);
		logic ok;
		cpu_handshake_model_i.exchange({ext, dev, r}, acc, data_buffer_register, ok);
		check({23'h0, ok}, {23'h0, ok_exp});
	endtask
	// Loads an input register word; held until the store reports it taken.
	task automatic put(input logic [4:0] a, input logic [15:0] d);
		int n;
		@(posedge clk);
		user_wr_valid <= 1'h1;
		user_wr_addr <= a;
		user_wr_data <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (taken !== 1'h1 && n < 20);
		user_wr_valid <= 1'h0;
		check({23'h0, taken}, 24'h000001);
	endtask
	task automatic t_reset();
		@(negedge clk);
		check({21'h0, done_n, request_n, bus_oe}, 24'h000006);
	endtask
	task automatic t_output();
		logic [15:0] data_buffer_register;
		int p;
		for (int d = 0; d < 3; d++) begin
			p = pulses;
			xfer(DEV_NUMS[8*d +: 8], 3'h1, 5'h00, 16'h5a00 + 16'(d), 1'h1, data_buffer_register);
			check({8'h0, data_buffer_register}, {8'h00, 16'h5a00 + 16'(d)});
			check({19'h0, wr_addr}, {19'h0, 2'(d), 3'h1});
			check({8'h0, wr_data}, {8'h00, 16'h5a00 + 16'(d)});
			check(24'(pulses - p), 24'h000001);
		end
	endtask
	task automatic t_input();
		logic [15:0] data_buffer_register;
		int p;
		p = pulses;
		for (int r = 0; r < 8; r++)
			put({2'h3, 3'(r)}, 16'hc300 + 16'(r));
		put(5'h15, 16'h7e2d);
		for (int r = 0; r < 8; r++) begin
			xfer(DEV_NUMS[31:24], 3'(r), 5'h00, 16'hffff, 1'h1, data_buffer_register);
			check({8'h0, data_buffer_register}, {8'h00, 16'hc300 + 16'(r)});
		end
		xfer(DEV_NUMS[23:16], 3'h5, 5'h00, 16'h0000, 1'h1, data_buffer_register);
		check({8'h0, data_buffer_register}, 24'h007e2d);
		check(24'(pulses - p), 24'h000000);
	endtask
	task automatic t_refuse();
		logic [15:0] data_buffer_register;
		int p;
		p = pulses;
		xfer(8'h77, 3'h1, 5'h00, 16'h1234, 1'h0, data_buffer_register);
		xfer(DEV_NUMS[7:0], 3'h1, 5'h10, 16'h1234, 1'h0, data_buffer_register);
		check(24'(pulses - p), 24'h000000);
		check({8'h0, wr_data}, 24'h005a02);
	endtask
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// A hung handshake ends the run here.
	initial begin
		#100000;
		fails++;
		summarize();
	end
	initial begin
		sys_rst = 1'h1;
		user_wr_valid = 1'h0;
		user_wr_addr = 5'h00;
		user_wr_data = 16'h0000;
		fails = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		t_reset();
		t_output();
		t_input();
		t_refuse();
		summarize();
	end
endmodule
